// ---- hdl/ctp_parser.v ----
// command tree header parser: tracks tree position over a stream of message bytes
`timescale 1ns/1ns
`include "ctp_defines.vh"
module ctp_parser #(
  parameter NODE_W = 8
) (
  input  wire              CLK_I,
  input  wire              RST_B_I,
  input  wire              BYTE_VALID_I,
  input  wire [7:0]        BYTE_DATA_I,
  output reg  [NODE_W-1:0] NODE_O,
  output reg               SUBSYS_SEL_O,
  output reg               UNIT_DONE_O,
  output reg  [NODE_W-1:0] UNIT_NODE_O,
  output reg  [NODE_W-1:0] UNIT_MNEM_O,
  output reg               UNIT_COMMON_O,
  output reg               UNIT_ROOT_O,
  output reg               MSG_END_O
);
  // mnemonics are folded into a rolling hash; the node id is the hash path of the parent
  // limitation: ids are short hashes, so two distinct paths may alias
  localparam [2:0] ST_START  = 3'b000;
  localparam [2:0] ST_HDR    = 3'b001;
  localparam [2:0] ST_COMMON = 3'b010;
  localparam [2:0] ST_PARAM  = 3'b011;
  reg [2:0]        state_reg;
  reg [2:0]        state_next;
  reg [NODE_W-1:0] node_reg;
  reg [NODE_W-1:0] node_next;
  reg [NODE_W-1:0] path_reg;
  reg [NODE_W-1:0] path_next;
  reg [NODE_W-1:0] mnem_reg;
  reg [NODE_W-1:0] mnem_next;
  reg              levels_reg;
  reg              levels_next;
  reg              colon_lead_reg;
  reg              colon_lead_next;
  reg              done_next;
  reg              msg_end_next;
  reg              common_next;
  reg              rootcmd_next;
  reg [NODE_W-1:0] unode_next;
  reg [NODE_W-1:0] umnem_next;
  wire [7:0] up = (BYTE_DATA_I >= 8'h61 && BYTE_DATA_I <= 8'h7A) ? BYTE_DATA_I - 8'h20 : BYTE_DATA_I;
  wire [NODE_W-1:0] mnem_fold = {mnem_reg[NODE_W-2:0], mnem_reg[NODE_W-1]} ^ up[NODE_W-1:0];
  wire [NODE_W-1:0] path_fold = {path_reg[NODE_W-2:0], path_reg[NODE_W-1]} ^ mnem_reg ^ 8'h5A;
  wire is_ws = (BYTE_DATA_I == `CTP_CH_SPACE) || (BYTE_DATA_I == `CTP_CH_TAB) || (BYTE_DATA_I == `CTP_CH_CR);
  // one mnemonic taken from the root, reached by message start or by a leading colon
  wire hdr_root = !levels_reg && (colon_lead_reg || path_reg == `CTP_NODE_ROOT);

  always @*
  begin
    state_next      = state_reg;
    node_next       = node_reg;
    path_next       = path_reg;
    mnem_next       = mnem_reg;
    levels_next     = levels_reg;
    colon_lead_next = colon_lead_reg;
    done_next       = 1'b0;
    msg_end_next    = 1'b0;
    common_next     = UNIT_COMMON_O;
    rootcmd_next    = UNIT_ROOT_O;
    unode_next      = UNIT_NODE_O;
    umnem_next      = UNIT_MNEM_O;
    if (BYTE_VALID_I)
    begin
      if (BYTE_DATA_I == `CTP_CH_LF)
      begin
        // terminator closes an open header or common unit, then homes the parser
        // parameter text was already reported when its header ended, so no second pulse
        if (state_reg == ST_HDR || state_reg == ST_COMMON)
        begin
          done_next    = 1'b1;
          unode_next   = path_reg;
          umnem_next   = mnem_reg;
          common_next  = (state_reg == ST_COMMON);
          rootcmd_next = (state_reg == ST_HDR) && hdr_root;
        end
        msg_end_next    = 1'b1;
        node_next       = `CTP_NODE_ROOT;
        path_next       = `CTP_NODE_ROOT;
        mnem_next       = `CTP_HASH_INIT;
        levels_next     = 1'b0;
        colon_lead_next = 1'b0;
        state_next      = ST_START;
      end
      else
      begin
        case (state_reg)
          ST_START:
          begin
            if (BYTE_DATA_I == `CTP_CH_COLON)
            begin
              path_next       = `CTP_NODE_ROOT;
              colon_lead_next = 1'b1;
              state_next      = ST_HDR;
            end
            else if (BYTE_DATA_I == `CTP_CH_STAR)
              state_next = ST_COMMON;
            else if (!is_ws && BYTE_DATA_I != `CTP_CH_SEMI)
            begin
              // bare mnemonic resolves against the node left by the last unit
              path_next  = node_reg;
              mnem_next  = mnem_fold;
              state_next = ST_HDR;
            end
          end
          ST_HDR:
          begin
            if (BYTE_DATA_I == `CTP_CH_COLON)
            begin
              path_next   = path_fold;
              mnem_next   = `CTP_HASH_INIT;
              levels_next = 1'b1;
            end
            else if (BYTE_DATA_I == `CTP_CH_SEMI || is_ws)
            begin
              // a space ends the header; the rest of the unit is parameter text
              done_next    = 1'b1;
              unode_next   = path_reg;
              umnem_next   = mnem_reg;
              common_next  = 1'b0;
              rootcmd_next = hdr_root;
              if (hdr_root)
                node_next = `CTP_NODE_ROOT;
              else
                node_next = path_reg;
              // hash restarts here, else a unit right after a semicolon folds in stale bits
              mnem_next       = `CTP_HASH_INIT;
              state_next      = (BYTE_DATA_I == `CTP_CH_SEMI) ? ST_START : ST_PARAM;
              levels_next     = 1'b0;
              colon_lead_next = 1'b0;
            end
            else
              mnem_next = mnem_fold;
          end
          ST_COMMON:
          begin
            // the common command name is not decoded; the tree position is left alone
            if (BYTE_DATA_I == `CTP_CH_SEMI)
            begin
              done_next    = 1'b1;
              common_next  = 1'b1;
              rootcmd_next = 1'b0;
              state_next   = ST_START;
            end
          end
          ST_PARAM:
          begin
            // limitation: a semicolon inside quoted parameter text still ends the unit
            if (BYTE_DATA_I == `CTP_CH_SEMI)
            begin
              mnem_next  = `CTP_HASH_INIT;
              state_next = ST_START;
            end
          end
          default:
            state_next = ST_START;
        endcase
      end
    end
  end

  // tree walk registers
  always @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      state_reg      <= ST_START;
      node_reg       <= `CTP_NODE_ROOT;
      path_reg       <= `CTP_NODE_ROOT;
      mnem_reg       <= `CTP_HASH_INIT;
      levels_reg     <= 1'b0;
      colon_lead_reg <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      node_reg       <= node_next;
      path_reg       <= path_next;
      mnem_reg       <= mnem_next;
      levels_reg     <= levels_next;
      colon_lead_reg <= colon_lead_next;
    end
  end

  // ports load the next values so each one comes straight from its own flop
  always @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      NODE_O        <= `CTP_NODE_ROOT;
      SUBSYS_SEL_O  <= 1'b0;
      UNIT_DONE_O   <= 1'b0;
      UNIT_NODE_O   <= `CTP_NODE_ROOT;
      UNIT_MNEM_O   <= `CTP_HASH_INIT;
      UNIT_COMMON_O <= 1'b0;
      UNIT_ROOT_O   <= 1'b0;
      MSG_END_O     <= 1'b0;
    end
    else
    begin
      NODE_O        <= node_next;
      SUBSYS_SEL_O  <= (node_next != `CTP_NODE_ROOT);
      UNIT_DONE_O   <= done_next;
      UNIT_NODE_O   <= unode_next;
      UNIT_MNEM_O   <= umnem_next;
      UNIT_COMMON_O <= common_next;
      UNIT_ROOT_O   <= rootcmd_next;
      MSG_END_O     <= msg_end_next;
    end
  end
endmodule // ctp_parser

// ---- hdl/ctp_defines.vh ----
// constants for the command tree header parser
`ifndef CTP_DEFINES_VH
`define CTP_DEFINES_VH
`define CTP_CH_LF     8'h0A
`define CTP_CH_CR     8'h0D
`define CTP_CH_COLON  8'h3A
`define CTP_CH_SEMI   8'h3B
`define CTP_CH_SPACE  8'h20
`define CTP_CH_STAR   8'h2A
`define CTP_CH_TAB    8'h09
`define CTP_NODE_ROOT 8'h00
`define CTP_HASH_INIT 8'h00
`endif

// ---- verif/ctp_checker_props.sv ----
// port assertions for the command tree parser
`timescale 1ns/1ns
module ctp_checker #(
  parameter NODE_W = 8
) (
  input wire              CLK_I,
  input wire              RST_B_I,
  input wire              BYTE_VALID_I,
  input wire [7:0]        BYTE_DATA_I,
  input wire [NODE_W-1:0] NODE_O,
  input wire              SUBSYS_SEL_O,
  input wire              UNIT_DONE_O,
  input wire [NODE_W-1:0] UNIT_NODE_O,
  input wire              UNIT_COMMON_O,
  input wire              UNIT_ROOT_O,
  input wire              MSG_END_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire lf = BYTE_VALID_I && BYTE_DATA_I == 8'h0A;
  wire sub = UNIT_DONE_O && !UNIT_ROOT_O && !UNIT_COMMON_O && !MSG_END_O;
  a_lf_root: assert property (lf |=> NODE_O == 0 && MSG_END_O) else $error("lf kept node");
  a_common_hold: assert property (UNIT_DONE_O && UNIT_COMMON_O && !MSG_END_O |-> NODE_O == $past(NODE_O)) else $error("common moved");
  a_root_ret: assert property (UNIT_DONE_O && UNIT_ROOT_O |-> NODE_O == 0) else $error("root unit kept node");
  a_root_base: assert property (UNIT_DONE_O && UNIT_ROOT_O |-> UNIT_NODE_O == 0) else $error("root unit base");
  a_sel_match: assert property (SUBSYS_SEL_O == (NODE_O != 0)) else $error("select flag off");
  a_rst_root: assert property ($rose(RST_B_I) |-> NODE_O == 0 && !SUBSYS_SEL_O) else $error("reset node");
  a_idle_quiet: assert property (!BYTE_VALID_I |=> !UNIT_DONE_O && !MSG_END_O) else $error("pulse w/o byte");
  a_end_by_lf: assert property (MSG_END_O |-> $past(lf)) else $error("end w/o lf");
  a_stay_parent: assert property (sub |-> NODE_O == UNIT_NODE_O) else $error("not at parent");
  c_common: cover property (UNIT_DONE_O && UNIT_COMMON_O);
  c_root: cover property (UNIT_DONE_O && UNIT_ROOT_O);
  c_sub: cover property (sub);
  c_lf_unit: cover property (UNIT_DONE_O && MSG_END_O);
endmodule // ctp_checker
bind ctp_parser ctp_checker #(.NODE_W(NODE_W)) chk_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .BYTE_VALID_I(BYTE_VALID_I), .BYTE_DATA_I(BYTE_DATA_I), .NODE_O(NODE_O), .SUBSYS_SEL_O(SUBSYS_SEL_O),
  .UNIT_DONE_O(UNIT_DONE_O), .UNIT_NODE_O(UNIT_NODE_O), .UNIT_COMMON_O(UNIT_COMMON_O),
  .UNIT_ROOT_O(UNIT_ROOT_O), .MSG_END_O(MSG_END_O));

// ---- verif/ctp_ctrl_model.sv ----
// remote controller model sending message text a byte per cycle
`timescale 1ns/1ns
module ctp_ctrl_model (
  input  wire       clk_i,
  output reg        valid_o,
  output reg  [7:0] data_o
);
  integer k;
  initial
  begin
    valid_o = 1'b0;
    data_o  = 8'hA5;
  end
  task send(input string s);
    begin
      for (k = 0; k < s.len(); k = k + 1)
      begin
        @(negedge clk_i);
        valid_o = 1'b1;
        data_o  = s[k];
      end
      @(negedge clk_i);
      valid_o = 1'b0;
      // idle data flips so a stale byte is never mistaken for a new one
      data_o  = ~data_o;
    end
  endtask
endmodule // ctp_ctrl_model

// ---- verif/tb.sv ----
// self-checking bench for the command tree parser
`timescale 1ns/1ns
module tb;
  reg        clk;
  reg        rst_b;
  wire       valid, sel, done, ucom, uroot, mend;
  wire [7:0] data, node, unode, umnem;
  integer    error_cnt = 0, n_compared = 0, cyc = 0;
  ctp_ctrl_model ctp_ctrl_model_inst (.clk_i(clk), .valid_o(valid), .data_o(data));
  ctp_parser ctp_parser_inst (.CLK_I(clk), .RST_B_I(rst_b), .BYTE_VALID_I(valid), .BYTE_DATA_I(data),
    .NODE_O(node), .SUBSYS_SEL_O(sel), .UNIT_DONE_O(done), .UNIT_NODE_O(unode), .UNIT_MNEM_O(umnem),
    .UNIT_COMMON_O(ucom), .UNIT_ROOT_O(uroot), .MSG_END_O(mend));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // run should end near 90 cycles; generous ceiling
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // node of "A" is rotl(0)^41^5A = 1B, of "C" is 43^5A = 19
  task t_compound;
    begin
      ctp_ctrl_model_inst.send(":A:B 5;C 0");
      chk(node, 8'h1B);
      chk(unode, 8'h1B);
      chk(umnem, 8'h43);
      chk(sel, 1'b1);
      ctp_ctrl_model_inst.send("\n");
      chk(mend, 1'b1);
      chk(done, 1'b0);
      chk(node, 8'h00);
      chk(sel, 1'b0);
      $display("compound done");
    end
  endtask
  task t_common;
    begin
      ctp_ctrl_model_inst.send(":A:B 1;*RST;");
      chk(ucom, 1'b1);
      chk(node, 8'h1B);
      ctp_ctrl_model_inst.send(":RUN;");
      chk(uroot, 1'b1);
      chk(node, 8'h00);
      chk(done, 1'b1);
      ctp_ctrl_model_inst.send(":A:B 1;");
      chk(node, 8'h1B);
      ctp_ctrl_model_inst.send(":A:B 1;:C:D 2;");
      chk(node, 8'h19);
      $display("common and root done");
    end
  endtask
  task t_cr;
    begin
      ctp_ctrl_model_inst.send("\nA:B\r\n");
      chk(umnem, 8'h42);
      chk(unode, 8'h1B);
      chk(node, 8'h00);
      // a bare mnemonic after a subsystem unit, closed by the terminator, is a subsystem unit, not a root one
      ctp_ctrl_model_inst.send(":A:B 1;C\n");
      chk(done, 1'b1);
      chk(mend, 1'b1);
      chk(uroot, 1'b0);
      chk(unode, 8'h1B);
      chk(umnem, 8'h43);
      $display("crlf done");
    end
  endtask
  task t_reset;
    begin
      ctp_ctrl_model_inst.send(":A:B 1;");
      chk(sel, 1'b1);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk(node, 8'h00);
      chk(sel, 1'b0);
      chk(unode, 8'h00);
      $display("mid-run reset done");
    end
  endtask
  initial
  begin
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(node, 8'h00);
    chk(sel, 1'b0);
    $display("reset done");
    t_compound;
    t_common;
    t_cr;
    t_reset;
    conclude;
  end
endmodule // tb
